// [common/usbsr_pkg.sv]
// Constants for the USB request report and endpoint status registers
`default_nettype none
package usbsr_pkg;
	localparam logic [15:0] CLEAR_FEATURE_REPORT_ADDR = 16'hff65;
	localparam logic [15:0] SET_REQUEST_REPORT_ADDR = 16'hff66;
	localparam logic [15:0] ENDPOINT_FIFO_STATUS0_ADDR = 16'hff67;
	localparam logic [15:0] INT_STATUS_ADDR = 16'hff68;
	localparam logic [15:0] INT_MASK_ADDR = 16'hff69;
	localparam logic [15:0] FIFO_CLEAR_REG_A_ADDR = 16'hff6a;
	localparam logic [15:0] FIFO_CLEAR_REG_B_ADDR = 16'hff6b;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Clear report fields
	localparam int DEVICE_CLEAR_DONE_BIT = 0;
	localparam int ENDPOINT_CLEAR_DONE_LSB = 1;
	localparam logic [7:0] CLEAR_REPORT_USED = 8'h0f;
	// Set report fields
	localparam int DEVICE_FEATURE_SET_DONE_BIT = 0;
	localparam int ENDPOINT_HALT_SET_DONE_BIT = 2;
	localparam int CONFIGURATION_SET_DONE_BIT = 7;
	localparam logic [7:0] SET_REPORT_USED = 8'h85;
	// Endpoint status fields
	localparam int CONTROL_OUT_HAS_DATA_BIT = 0;
	localparam int CONTROL_IN_HAS_DATA_BIT = 1;
	localparam int BULK_IN_HAS_DATA_BIT = 2;
	localparam int BULK_OUT_HAS_DATA_BIT = 4;
	localparam logic [7:0] STATUS0_USED = 8'h17;
	localparam logic [1:0] LAST_ENDPOINT = 2'h2;
	// Interrupt event bits
	localparam int INT_CLEAR_REPORT_BIT = 0;
	localparam int INT_SET_REPORT_BIT = 1;
	localparam int INT_FIFO_CLEAR_BIT = 2;
	localparam logic [2:0] INT_RESET = 3'h0;
	// Status reflects a FIFO clear five USB clocks later
	localparam int CLK_MHZ = 100;
	localparam int FIFO_CLEAR_LATENCY_NS = 50;
	localparam int FIFO_CLEAR_CYC = (FIFO_CLEAR_LATENCY_NS * CLK_MHZ + 999) / 1000;
	localparam logic [2:0] CLEAR_CNT_LOAD = 3'(FIFO_CLEAR_CYC);
	localparam logic [2:0] CLEAR_CNT_FIRE = 3'h1;
	localparam logic [2:0] CLEAR_CNT_IDLE = 3'h0;
endpackage
`default_nettype wire

// [core/usbsr_top.sv]
// Request report, endpoint status and interrupt registers of the USB function
// Function
// - Read-only byte telling which device or endpoint a CLEAR_FEATURE addressed.
// - Report flags set after status stage; whole register clears when read.
// - Endpoint 1 and 2 flags invalid while those endpoints are disabled.
// - Bits 3..1 flag CLEAR_FEATURE handled for endpoint 2..0; reset zero.
// - Bit 0 flags CLEAR_FEATURE to the device handled; reset zero.
// - Read-only byte reporting handled SET requests; SET_INTERFACE never shown.
// - Bit 7 of set report flags SET_CONFIGURATION handled.
// - Bit 2 of set report flags SET_FEATURE to endpoint 0..2.
// - Bit 0 of set report flags SET_FEATURE to the device.
// - Read-only status byte shows which endpoint FIFOs hold data.
// - A FIFO clear write shows in status after five clocks.
// - Bulk-out flag set on toggle, cleared when read empty, not on null.
// - Control-in flag set on data or null request, cleared on transmission.
`default_nettype none
module usbsr_top (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Request completion from the protocol engine
	input wire logic CLR_FEAT_DONE,
	input wire logic SET_FEAT_DONE,
	input wire logic SET_CFG_DONE,
	input wire logic REQ_TO_EP,
	input wire logic [1:0] REQ_EP_NUM,
	// Endpoints 1 and 2 enabled by mapping and interface setting
	input wire logic [1:0] EP_ENABLE,
	// FIFO events
	input wire logic BO_TOGGLE,
	input wire logic BO_ZLP,
	input wire logic BO_READ_EMPTY,
	input wire logic BI_LOADED,
	input wire logic BI_TOGGLE,
	input wire logic CI_LOADED,
	input wire logic CI_ZLP_REQ,
	input wire logic CI_TX_OK,
	input wire logic CO_RECEIVED,
	input wire logic CO_READ_EMPTY,
	// Interrupt
	output logic IRQ
);
	typedef struct packed {
		logic [7:0] clr_rep;
		logic [7:0] set_rep;
		logic [7:0] eps;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic [7:0] clr_pend;
		logic [2:0] clr_cnt;
		logic [7:0] rdata;
		logic irq;
	} usbsr_state_t;

	usbsr_state_t st_reg;
	usbsr_state_t st_next;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	// Endpoint usable: 0 always, 1 and 2 by enable
	function automatic logic ep_ok(input logic [1:0] ep, input logic [1:0] en);
		ep_ok = (ep == 2'h0)
			|| (ep == 2'h1 && en[0])
			|| (ep == usbsr_pkg::LAST_ENDPOINT && en[1]);
	endfunction

	logic rd_clr;
	logic rd_set;
	logic ep_valid;
	logic [7:0] clr_ev;
	logic [7:0] set_ev;
	logic [7:0] ep_mask;

	always_comb begin
		rd_clr = RD && hit(ADDR, usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR);
		rd_set = RD && hit(ADDR, usbsr_pkg::SET_REQUEST_REPORT_ADDR);
		ep_valid = REQ_TO_EP && ep_ok(REQ_EP_NUM, EP_ENABLE);
		clr_ev = 8'h00;
		set_ev = 8'h00;
		// Events arrive at the end of the status stage
		if (CLR_FEAT_DONE && !REQ_TO_EP) begin
			clr_ev[usbsr_pkg::DEVICE_CLEAR_DONE_BIT] = 1'b1;
		end
		if (CLR_FEAT_DONE && ep_valid) begin
			clr_ev[usbsr_pkg::ENDPOINT_CLEAR_DONE_LSB + int'(REQ_EP_NUM)] = 1'b1;
		end
		if (SET_FEAT_DONE && !REQ_TO_EP) begin
			set_ev[usbsr_pkg::DEVICE_FEATURE_SET_DONE_BIT] = 1'b1;
		end
		if (SET_FEAT_DONE && ep_valid) begin
			set_ev[usbsr_pkg::ENDPOINT_HALT_SET_DONE_BIT] = 1'b1;
		end
		if (SET_CFG_DONE) begin
			set_ev[usbsr_pkg::CONFIGURATION_SET_DONE_BIT] = 1'b1;
		end
		// Hide data flags of disabled endpoints
		ep_mask = usbsr_pkg::STATUS0_USED;
		ep_mask[usbsr_pkg::BULK_IN_HAS_DATA_BIT] = EP_ENABLE[0];
		ep_mask[usbsr_pkg::BULK_OUT_HAS_DATA_BIT] = EP_ENABLE[1];
	end

	always_comb begin
		st_next = st_reg;
		// Read clears, a simultaneous set survives
		st_next.clr_rep = ((rd_clr ? 8'h00 : st_reg.clr_rep) | clr_ev)
			& usbsr_pkg::CLEAR_REPORT_USED;
		st_next.set_rep = ((rd_set ? 8'h00 : st_reg.set_rep) | set_ev)
			& usbsr_pkg::SET_REPORT_USED;
		// Delayed FIFO clear first, so a data event in the same cycle still sets
		st_next.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT] = 1'b0;
		if (st_reg.clr_cnt == usbsr_pkg::CLEAR_CNT_FIRE) begin
			st_next.eps = st_reg.eps & ~st_reg.clr_pend;
			st_next.clr_pend = 8'h00;
			st_next.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT] = 1'b1;
		end
		// FIFO data flags
		if (BO_TOGGLE && !BO_ZLP) begin
			st_next.eps[usbsr_pkg::BULK_OUT_HAS_DATA_BIT] = 1'b1;
		end else if (BO_READ_EMPTY) begin
			st_next.eps[usbsr_pkg::BULK_OUT_HAS_DATA_BIT] = 1'b0;
		end
		if (BI_LOADED) begin
			st_next.eps[usbsr_pkg::BULK_IN_HAS_DATA_BIT] = 1'b1;
		end else if (BI_TOGGLE) begin
			st_next.eps[usbsr_pkg::BULK_IN_HAS_DATA_BIT] = 1'b0;
		end
		if (CI_LOADED || CI_ZLP_REQ) begin
			st_next.eps[usbsr_pkg::CONTROL_IN_HAS_DATA_BIT] = 1'b1;
		end else if (CI_TX_OK) begin
			st_next.eps[usbsr_pkg::CONTROL_IN_HAS_DATA_BIT] = 1'b0;
		end
		if (CO_RECEIVED) begin
			st_next.eps[usbsr_pkg::CONTROL_OUT_HAS_DATA_BIT] = 1'b1;
		end else if (CO_READ_EMPTY) begin
			st_next.eps[usbsr_pkg::CONTROL_OUT_HAS_DATA_BIT] = 1'b0;
		end
		// Count down towards the delayed clear
		if (st_reg.clr_cnt != usbsr_pkg::CLEAR_CNT_IDLE) begin
			st_next.clr_cnt = st_reg.clr_cnt - 3'h1;
		end
		if (WR && (hit(ADDR, usbsr_pkg::FIFO_CLEAR_REG_A_ADDR)
				|| hit(ADDR, usbsr_pkg::FIFO_CLEAR_REG_B_ADDR))) begin
			st_next.clr_pend = (st_next.clr_pend | WDATA) & usbsr_pkg::STATUS0_USED;
			st_next.clr_cnt = usbsr_pkg::CLEAR_CNT_LOAD;
		end
		st_next.eps = st_next.eps & usbsr_pkg::STATUS0_USED;
		// Interrupt status: sticky, write one to clear, set wins
		st_next.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT] =
			st_next.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT]
			| st_reg.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT];
		if (WR && hit(ADDR, usbsr_pkg::INT_STATUS_ADDR)) begin
			st_next.int_stat = st_next.int_stat & ~WDATA[2:0];
			if (st_reg.clr_cnt == usbsr_pkg::CLEAR_CNT_FIRE) begin
				st_next.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT] = 1'b1;
			end
		end
		if (clr_ev != 8'h00) begin
			st_next.int_stat[usbsr_pkg::INT_CLEAR_REPORT_BIT] = 1'b1;
		end
		if (set_ev != 8'h00) begin
			st_next.int_stat[usbsr_pkg::INT_SET_REPORT_BIT] = 1'b1;
		end
		if (WR && hit(ADDR, usbsr_pkg::INT_MASK_ADDR)) begin
			st_next.int_mask = WDATA[2:0];
		end
		st_next.irq = |(st_next.int_stat & st_next.int_mask);
		// Read data, one cycle after the strobe; unmapped reads zero
		st_next.rdata = 8'h00;
		if (RD) begin
			if (hit(ADDR, usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR)) begin
				st_next.rdata = st_reg.clr_rep;
			end else if (hit(ADDR, usbsr_pkg::SET_REQUEST_REPORT_ADDR)) begin
				st_next.rdata = st_reg.set_rep;
			end else if (hit(ADDR, usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR)) begin
				st_next.rdata = st_reg.eps & ep_mask;
			end else if (hit(ADDR, usbsr_pkg::INT_STATUS_ADDR)) begin
				st_next.rdata = {5'h00, st_reg.int_stat};
			end else if (hit(ADDR, usbsr_pkg::INT_MASK_ADDR)) begin
				st_next.rdata = {5'h00, st_reg.int_mask};
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg.clr_rep <= usbsr_pkg::REG_RESET;
			st_reg.set_rep <= usbsr_pkg::REG_RESET;
			st_reg.eps <= usbsr_pkg::REG_RESET;
			st_reg.int_stat <= usbsr_pkg::INT_RESET;
			st_reg.int_mask <= usbsr_pkg::INT_RESET;
			st_reg.clr_pend <= usbsr_pkg::REG_RESET;
			st_reg.clr_cnt <= usbsr_pkg::CLEAR_CNT_IDLE;
			st_reg.rdata <= usbsr_pkg::REG_RESET;
			st_reg.irq <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RDATA = st_reg.rdata;
	assign IRQ = st_reg.irq;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_clear_write;
		WR && (ADDR == usbsr_pkg::FIFO_CLEAR_REG_A_ADDR) && WDATA[1];
	endsequence
	sequence s_quiet_ctrl_in;
		!CI_LOADED && !CI_ZLP_REQ && !(WR && (ADDR == usbsr_pkg::FIFO_CLEAR_REG_A_ADDR
			|| ADDR == usbsr_pkg::FIFO_CLEAR_REG_B_ADDR));
	endsequence
	// No further FIFO clear write restarting the count
	sequence s_no_rewrite;
		!(WR && (ADDR == usbsr_pkg::FIFO_CLEAR_REG_A_ADDR
			|| ADDR == usbsr_pkg::FIFO_CLEAR_REG_B_ADDR));
	endsequence
	// Software read of the endpoint status byte
	sequence s_status_read;
		RD && (ADDR == usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR);
	endsequence

	AST_CLR_DEVICE: assert property (CLR_FEAT_DONE && !REQ_TO_EP |=> st_reg.clr_rep[0])
		else $error("device clear flag not set");
	AST_CLR_EP: assert property (CLR_FEAT_DONE && REQ_TO_EP && REQ_EP_NUM == 2'h0
		|=> st_reg.clr_rep[1])
		else $error("endpoint 0 clear flag not set");
	AST_READ_CLEARS: assert property (RD && ADDR == usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR
		&& !CLR_FEAT_DONE |=> st_reg.clr_rep == 8'h00 && RDATA == $past(st_reg.clr_rep))
		else $error("clear report not cleared by read");
	AST_SET_KEPT: assert property (rd_set && SET_CFG_DONE |=> st_reg.set_rep[7])
		else $error("set lost against read clear");
	AST_SET_EP: assert property (SET_FEAT_DONE && REQ_TO_EP && REQ_EP_NUM == 2'h0
		|=> st_reg.set_rep[2] && !st_reg.set_rep[1])
		else $error("endpoint halt set flag wrong");
	AST_SET_DEV: assert property (SET_FEAT_DONE && !REQ_TO_EP |=> st_reg.set_rep[0])
		else $error("device feature set flag wrong");
	AST_EP_DISABLED: assert property (CLR_FEAT_DONE && REQ_TO_EP && REQ_EP_NUM == 2'h2
		&& !EP_ENABLE[1] && !rd_clr |=> st_reg.clr_rep[3] == $past(st_reg.clr_rep[3]))
		else $error("disabled endpoint flag set");
	AST_UNUSED_ZERO: assert property ((st_reg.clr_rep & ~usbsr_pkg::CLEAR_REPORT_USED) == 8'h00
		&& (st_reg.set_rep & ~usbsr_pkg::SET_REPORT_USED) == 8'h00)
		else $error("unused bit set");
	AST_FIFO_CLEAR_5: assert property (s_clear_write ##1 s_quiet_ctrl_in [*5]
		|=> st_reg.clr_cnt == usbsr_pkg::CLEAR_CNT_IDLE && !st_reg.eps[1])
		else $error("control in flag not cleared five clocks after clear");
	AST_ZLP_IN: assert property (CI_ZLP_REQ |=> st_reg.eps[1])
		else $error("null request did not set control in flag");
	AST_BULK_NULL: assert property (BO_ZLP |=> st_reg.eps[4] == $past(st_reg.eps[4])
		|| $past(BO_READ_EMPTY) || $past(st_reg.clr_cnt) == usbsr_pkg::CLEAR_CNT_FIRE)
		else $error("null packet changed bulk out flag");
	AST_IRQ: assert property (st_reg.int_stat[0] && st_reg.int_mask[0] && !(WR) |=> IRQ)
		else $error("interrupt not raised");

	// Request reports, read clears and set wins
	AST_SET_CFG: assert property (SET_CFG_DONE |=> st_reg.set_rep[7])
		else $error("configuration set flag not set");
	AST_CLR_EP1: assert property (CLR_FEAT_DONE && REQ_TO_EP
		&& REQ_EP_NUM == 2'h1 && EP_ENABLE[0] |=> st_reg.clr_rep[2])
		else $error("endpoint 1 clear flag not set");
	AST_CLR_EP2: assert property (CLR_FEAT_DONE && REQ_TO_EP
		&& REQ_EP_NUM == 2'h2 && EP_ENABLE[1] |=> st_reg.clr_rep[3])
		else $error("endpoint 2 clear flag not set");
	AST_CLR_KEPT: assert property (rd_clr && CLR_FEAT_DONE && REQ_TO_EP
		&& REQ_EP_NUM == 2'h0 |=> st_reg.clr_rep[1])
		else $error("endpoint clear flag lost against read clear");
	AST_SET_READ_CLEARS: assert property (rd_set && !SET_FEAT_DONE && !SET_CFG_DONE
		|=> st_reg.set_rep == 8'h00 && RDATA == $past(st_reg.set_rep))
		else $error("set report not cleared by read");

	// Endpoint status byte as software reads it
	AST_STATUS_USED: assert property (s_status_read
		|=> (RDATA & ~usbsr_pkg::STATUS0_USED) == 8'h00)
		else $error("unused status bit read as one");
	AST_STATUS_HIDE: assert property (s_status_read ##0 !EP_ENABLE[0]
		|=> !RDATA[usbsr_pkg::BULK_IN_HAS_DATA_BIT])
		else $error("disabled endpoint data flag shown");

	// FIFO data flags and the delayed clear
	AST_BULK_OUT_EMPTY: assert property (BO_READ_EMPTY && !(BO_TOGGLE && !BO_ZLP)
		|=> !st_reg.eps[usbsr_pkg::BULK_OUT_HAS_DATA_BIT])
		else $error("bulk out flag not cleared when read empty");
	AST_CI_TX: assert property (CI_TX_OK && !CI_LOADED && !CI_ZLP_REQ
		|=> !st_reg.eps[usbsr_pkg::CONTROL_IN_HAS_DATA_BIT])
		else $error("control in flag not cleared after transmission");
	AST_FIFO_IRQ: assert property (st_reg.clr_cnt == usbsr_pkg::CLEAR_CNT_FIRE
		|=> st_reg.int_stat[usbsr_pkg::INT_FIFO_CLEAR_BIT])
		else $error("FIFO clear completion not flagged");
	AST_CLEAR_COUNT: assert property (s_clear_write ##1 s_no_rewrite [*4]
		|=> st_reg.clr_cnt == usbsr_pkg::CLEAR_CNT_FIRE)
		else $error("FIFO clear count out of step");
endmodule
`default_nettype wire

// [verification/usb_std_request_status_regs_tb.sv]
// Self-checking bench for the request report and endpoint status registers
`default_nettype none
module usb_std_request_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic [1:0] ep_en = 2'h3;
	logic [2:0] done;
	logic to_ep;
	logic [1:0] ep_num;
	logic [9:0] ev;
	logic [7:0] d;
	int num_errors = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	usbsr_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .CLR_FEAT_DONE(done[0]), .SET_FEAT_DONE(done[1]),
		.SET_CFG_DONE(done[2]), .REQ_TO_EP(to_ep), .REQ_EP_NUM(ep_num), .EP_ENABLE(ep_en),
		.BO_TOGGLE(ev[0]), .BO_ZLP(ev[1]), .BO_READ_EMPTY(ev[2]), .BI_LOADED(ev[3]),
		.BI_TOGGLE(ev[4]), .CI_LOADED(ev[5]), .CI_ZLP_REQ(ev[6]), .CI_TX_OK(ev[7]),
		.CO_RECEIVED(ev[8]), .CO_READ_EMPTY(ev[9]), .IRQ(irq));
	usbsr_engine_model u_eng (.clk(clk), .done(done), .to_ep(to_ep), .ep_num(ep_num),
		.ev(ev));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic exp_reg(input logic [15:0] a, input logic [7:0] v);
		rd_reg(a, d);
		chk($sformatf("reg %h", a), d, v);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 3; i++) begin
			exp_reg(16'hff65 + 16'(i), 8'h00);
			wr_reg(16'hff65 + 16'(i), 8'hff);
			exp_reg(16'hff65 + 16'(i), 8'h00);
		end
		exp_reg(16'hff00, 8'h00);
	endtask
	task automatic t_clear;
		wr_reg(usbsr_pkg::INT_MASK_ADDR, 8'h07);
		for (int i = 0; i < 4; i++) begin
			u_eng.req(0, i != 0, 2'(i - 1));
			exp_reg(usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR, 8'(1 << i));
			exp_reg(usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR, 8'h00);
		end
		chk("irq", {7'h0, irq}, 8'h01);
		@(posedge clk);
		ep_en <= 2'h0;
		for (int i = 1; i < 4; i++)
			u_eng.req(0, 1'b1, 2'(i));
		exp_reg(usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR, 8'h00);
		@(posedge clk);
		ep_en <= 2'h3;
		u_eng.req(0, 1'b0, 2'h0);
		fork
			rd_reg(usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR, d);
			u_eng.req(0, 1'b1, 2'h0);
		join
		chk("clear report", d, 8'h01);
		exp_reg(usbsr_pkg::CLEAR_FEATURE_REPORT_ADDR, 8'h02);
	endtask
	task automatic t_set;
		u_eng.req(2, 1'b0, 2'h0);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h80);
		u_eng.req(1, 1'b1, 2'h2);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h04);
		u_eng.req(1, 1'b0, 2'h0);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h01);
		u_eng.req(2, 1'b0, 2'h0);
		u_eng.req(1, 1'b1, 2'h0);
		u_eng.req(1, 1'b0, 2'h0);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h85);
		fork
			rd_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, d);
			u_eng.req(2, 1'b0, 2'h0);
		join
		chk("set report", d, 8'h00);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h80);
	endtask
	task automatic t_irq;
		wr_reg(usbsr_pkg::INT_STATUS_ADDR, 8'h07);
		wr_reg(usbsr_pkg::INT_MASK_ADDR, 8'h00);
		u_eng.req(2, 1'b0, 2'h0);
		exp_reg(usbsr_pkg::INT_STATUS_ADDR, 8'h02);
		chk("irq masked", {7'h0, irq}, 8'h00);
		wr_reg(usbsr_pkg::INT_MASK_ADDR, 8'h02);
		#1 chk("irq unmasked", {7'h0, irq}, 8'h01);
		exp_reg(usbsr_pkg::SET_REQUEST_REPORT_ADDR, 8'h80);
		wr_reg(usbsr_pkg::INT_STATUS_ADDR, 8'h02);
		#1 chk("irq cleared", {7'h0, irq}, 8'h00);
		wr_reg(usbsr_pkg::INT_MASK_ADDR, 8'h04);
	endtask
	task automatic t_fifo;
		u_eng.fifo(10'h129);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h17);
		u_eng.fifo(10'h004);
		u_eng.fifo(10'h003);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h07);
		@(posedge clk);
		ep_en <= 2'h2;
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h03);
		@(posedge clk);
		ep_en <= 2'h3;
		u_eng.fifo(10'h080);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h05);
		u_eng.fifo(10'h040);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h07);
		wr_reg(usbsr_pkg::FIFO_CLEAR_REG_A_ADDR, 8'h02);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h07);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h07);
		chk("irq before clear", {7'h0, irq}, 8'h00);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h05);
		chk("irq after clear", {7'h0, irq}, 8'h01);
		wr_reg(usbsr_pkg::FIFO_CLEAR_REG_B_ADDR, 8'h15);
		repeat (5) @(posedge clk);
		exp_reg(usbsr_pkg::ENDPOINT_FIFO_STATUS0_ADDR, 8'h00);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_clear;
		t_set;
		t_irq;
		t_fifo;
		tally_and_finish;
	end
	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// [verification/usbsr_engine_model.sv]
// Protocol engine model issuing request completions and FIFO events
`default_nettype none
module usbsr_engine_model (
	// Clock
	input wire logic clk,
	// Request completion
	output logic [2:0] done,
	output logic to_ep,
	output logic [1:0] ep_num,
	// FIFO events
	output logic [9:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		done = 3'h0;
		to_ep = 1'b0;
		ep_num = 2'h0;
		ev = 10'h000;
	end
	// One pulse per finished status stage; target scrambled afterwards
	task automatic req(input int kind, input logic tgt, input logic [1:0] num);
		@(posedge clk);
		done[kind] <= 1'b1;
		to_ep <= tgt;
		ep_num <= num;
		@(posedge clk);
		done <= 3'h0;
		to_ep <= ~tgt;
		ep_num <= ~num;
	endtask
	task automatic fifo(input logic [9:0] bits);
		@(posedge clk);
		ev <= bits;
		@(posedge clk);
		ev <= 10'h000;
	endtask
endmodule
`default_nettype wire
